// ### rtl/tone_defines.svh
// Offsets, field positions, reset values and timing counts of the tone generator
`ifndef TONE_DEFINES_SVH
`define TONE_DEFINES_SVH

// Register byte offsets
`define TONE_CTRL_OFFSET       4'h0
`define TONE_PORTC_OFFSET      4'h4
`define TONE_STATUS_OFFSET     4'h8

// Reset values
`define TONE_CTRL_RESET        8'h00
`define TONE_PORTC_RESET       8'h00

// Control register fields
`define TONE_PERIOD_LSB        0
`define TONE_PERIOD_MSB        5
`define TONE_PRESC_LSB         6
`define TONE_PRESC_MSB         7

// Port C low configuration: buzzer function select bit
`define TONE_PORTC_BUZ_BIT     2

// Status register fields
`define TONE_STAT_EN_BIT       0
`define TONE_STAT_LEVEL_BIT    1
`define TONE_STAT_PIN_BIT      2
`define TONE_STAT_CNT_LSB      8
`define TONE_STAT_CNT_MSB      13

// Tone counter limits
`define TONE_CNT_MAX           6'h3f

// Default prescaler ratios for codes 00, 01, 10, 11
`define TONE_DIV_CODE0         4
`define TONE_DIV_CODE1         8
`define TONE_DIV_CODE2         16
`define TONE_DIV_CODE3         64

// Bus response codes
`define TONE_RESP_OKAY         2'b00
`define TONE_RESP_SLVERR       2'b10

`endif

// ### rtl/tone_pkg.sv
// Types shared by the tone generator modules
package tone_pkg;

	// Control register layout, msb first
	typedef struct packed {
		logic [1:0] presc_sel;
		logic [5:0] period;
	} tone_ctrl_t;

	// Register selected by a bus address
	typedef enum logic [1:0] {
		SEL_CTRL   = 2'b00,
		SEL_PORTC  = 2'b01,
		SEL_STATUS = 2'b10,
		SEL_NONE   = 2'b11
	} reg_sel_t;

	// Tone output activity
	typedef enum logic {
		TONE_OFF = 1'b0,
		TONE_RUN = 1'b1
	} tone_state_t;

endpackage : tone_pkg

// ### rtl/tone_prescaler.sv
// Clock divider that paces the tone counter
`timescale 1ns/1ps
`default_nettype none
`include "tone_defines.svh"

module tone_prescaler
	import tone_pkg::*;
#(
	parameter int DIV0 = `TONE_DIV_CODE0,
	parameter int DIV1 = `TONE_DIV_CODE1,
	parameter int DIV2 = `TONE_DIV_CODE2,
	parameter int DIV3 = `TONE_DIV_CODE3
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       clear,
	input  wire logic [1:0] sel,
	output logic            tick
);

	// Ratios must be powers of two that a 6-bit count can reach
	function automatic bit ratio_ok(input int r);
		ratio_ok = (r >= 1) && (r <= 64) && ((r & (r - 1)) == 0);
	endfunction : ratio_ok

	// Refused at elaboration, before any clock runs
	if (!ratio_ok(DIV0) || !ratio_ok(DIV1) || !ratio_ok(DIV2) || !ratio_ok(DIV3)) begin : g_bad_ratio
		$error("tone_prescaler: ratio not a power of two in 1..64");
	end

	localparam logic [5:0] LIM0 = 6'(DIV0 - 1);
	localparam logic [5:0] LIM1 = 6'(DIV1 - 1);
	localparam logic [5:0] LIM2 = 6'(DIV2 - 1);
	localparam logic [5:0] LIM3 = 6'(DIV3 - 1);

	logic [5:0] cnt_q;
	logic [5:0] cnt_d;
	logic [5:0] lim;

	// Ratio table, one entry per selection code
	assign lim   = (sel == 2'b00) ? LIM0 :
	               (sel == 2'b01) ? LIM1 :
	               (sel == 2'b10) ? LIM2 : LIM3; // RL10 RL7
	assign tick  = ~clear & (cnt_q >= lim);
	assign cnt_d = (clear || tick) ? 6'h00 : cnt_q + 6'h01;

	// Divider restarts with the tone so the first half period is full length
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 6'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule : tone_prescaler

`default_nettype wire

// ### rtl/tone_square_wave_generator.sv
// Buzzer tone generator with AXI4-Lite register access
//
// Overview of operation
// (RL1) 6-bit up-counter behind a clock divider; control register holds divider and period.
// (RL2) Buzzer pin carries a square wave with equal high and low phases.
// (RL3) On enable the counter clears, the pin goes low, then counting starts.
// (RL4) Counter equal to period field: pin inverts and counter clears.
// (RL5) Counter also clears when it passes its 6-bit maximum.
// (RL6) Tone frequency is clock over two, over prescaler ratio, over period plus one.
// (RL7) Control bits 7-6 pick the prescaler; code 11 divides by 64.
// (RL8) Setting port C low config bit 2 gives the pin its buzzer function.
// (RL9) Returning the pin to input mode stops the tone drive.
// (RL10) Ratios for codes 00, 01, 10 come from a power-of-two parameter table.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tone_defines.svh"

module tone_square_wave_generator
	import tone_pkg::*;
#(
	parameter int ADDR_W = 4,
	parameter int DIV0   = `TONE_DIV_CODE0,
	parameter int DIV1   = `TONE_DIV_CODE1,
	parameter int DIV2   = `TONE_DIV_CODE2,
	parameter int DIV3   = `TONE_DIV_CODE3
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              wvalid,
	output logic                   wready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	output logic                   bvalid,
	input  wire logic              bready,
	output logic [1:0]             bresp,
	input  wire logic              arvalid,
	output logic                   arready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	input  wire logic              buzzer_pin_in,
	output logic                   buzzer_pin_out,
	output logic                   buzzer_pin_oe
);

	if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
		$error("tone_square_wave_generator: ADDR_W must be 4..32");
	end

	// Address decode shared by the read and write paths
	function automatic reg_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-1:0] word;
		word = addr & ~ADDR_W'(3);
		if (word == ADDR_W'(`TONE_CTRL_OFFSET)) begin
			reg_sel = SEL_CTRL;
		end else if (word == ADDR_W'(`TONE_PORTC_OFFSET)) begin
			reg_sel = SEL_PORTC;
		end else if (word == ADDR_W'(`TONE_STATUS_OFFSET)) begin
			reg_sel = SEL_STATUS;
		end else begin
			reg_sel = SEL_NONE;
		end
	endfunction : reg_sel

	// Write channel state
	logic              aw_held_q;
	logic              aw_held_d;
	logic [ADDR_W-1:0] awaddr_q;
	logic              w_held_q;
	logic              w_held_d;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              awready_q;
	logic              awready_d;
	logic              wready_q;
	logic              wready_d;
	logic              bvalid_q;
	logic              bvalid_d;
	logic [1:0]        bresp_q;

	// Read channel state
	logic              arready_q;
	logic              arready_d;
	logic              rvalid_q;
	logic              rvalid_d;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;

	// Registers
	tone_ctrl_t        ctrl_q;
	logic [7:0]        portc_q;

	// Tone core state
	tone_state_t       state_q;
	logic [5:0]        tcnt_q;
	logic [5:0]        tcnt_d;
	logic              level_q;
	logic              level_d;
	logic              out_q;
	logic              oe_q;
	logic              pin_meta_q;
	logic              pin_sync_q;

	// Write handshake decode
	wire               aw_take   = awvalid & awready_q;
	wire               w_take    = wvalid & wready_q;
	wire               aw_have   = aw_held_q | aw_take;
	wire               w_have    = w_held_q | w_take;
	wire               do_write  = aw_have & w_have & ~bvalid_q;
	wire [ADDR_W-1:0]  wr_addr   = aw_held_q ? awaddr_q : awaddr;
	wire [31:0]        wr_data   = w_held_q ? wdata_q : wdata;
	wire [3:0]         wr_strb   = w_held_q ? wstrb_q : wstrb;
	wire reg_sel_t     wr_sel    = reg_sel(wr_addr);
	wire               wr_low    = do_write & wr_strb[0];
	wire               wr_ctrl   = wr_low & (wr_sel == SEL_CTRL);
	wire               wr_portc  = wr_low & (wr_sel == SEL_PORTC);
	wire [1:0]         wr_resp   = (wr_sel == SEL_NONE) ? `TONE_RESP_SLVERR : `TONE_RESP_OKAY;

	assign aw_held_d = aw_have & ~do_write;
	assign w_held_d  = w_have & ~do_write;
	assign bvalid_d  = do_write | (bvalid_q & ~bready);
	assign awready_d = ~aw_held_d & ~bvalid_d;
	assign wready_d  = ~w_held_d & ~bvalid_d;

	// Read handshake decode
	wire               ar_take   = arvalid & arready_q;
	wire reg_sel_t     rd_sel    = reg_sel(araddr);
	wire [31:0]        status_w;
	wire [31:0]        rd_data;
	wire [1:0]         rd_resp   = (rd_sel == SEL_NONE) ? `TONE_RESP_SLVERR : `TONE_RESP_OKAY;

	assign rvalid_d  = ar_take | (rvalid_q & ~rready);
	assign arready_d = ~rvalid_d;

	// Status word: live tone state, counter and the pin as seen from outside
	assign status_w = {18'h00000,
	                   tcnt_q,
	                   5'h00,
	                   pin_sync_q,
	                   level_q,
	                   (state_q == TONE_RUN)};
	assign rd_data  = (rd_sel == SEL_CTRL)   ? {24'h000000, ctrl_q} :
	                  (rd_sel == SEL_PORTC)  ? {24'h000000, portc_q} :
	                  (rd_sel == SEL_STATUS) ? status_w : 32'h00000000;

	// Write address and data may arrive in either order; each is parked until paired
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= 32'h00000000;
			wstrb_q   <= 4'h0;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q  <= w_held_d;
			if (aw_take) begin
				awaddr_q <= awaddr;
			end
			if (w_take) begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
		end
	end

	// Write response and ready flags, registered so outputs come from flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `TONE_RESP_OKAY;
		end else begin
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			if (do_write) begin
				bresp_q <= wr_resp;
			end
		end
	end

	// Read path answers one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= `TONE_RESP_OKAY;
		end else begin
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			if (ar_take) begin
				rdata_q <= rd_data;
				rresp_q <= rd_resp;
			end
		end
	end

	// Software-visible registers; only byte lane 0 carries bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q  <= tone_ctrl_t'(`TONE_CTRL_RESET);
			portc_q <= `TONE_PORTC_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= tone_ctrl_t'(wr_data[7:0]); // RL1
			end
			if (wr_portc) begin
				portc_q <= wr_data[7:0];
			end
		end
	end

	// Buzzer function select and start of a tone
	wire               buz_sel   = portc_q[`TONE_PORTC_BUZ_BIT]; // RL8 RL9
	wire               start     = buz_sel & (state_q == TONE_OFF); // RL3
	wire               tick;
	wire               match     = (tcnt_q == ctrl_q.period); // RL4
	wire               overflow  = (tcnt_q == `TONE_CNT_MAX);

	// Divider is held cleared while idle and at start, so each tone begins aligned
	tone_prescaler #(
		.DIV0 (DIV0),
		.DIV1 (DIV1),
		.DIV2 (DIV2),
		.DIV3 (DIV3)
	) u_prescaler (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clear   (~buz_sel | start),
		.sel     (ctrl_q.presc_sel),
		.tick    (tick)
	); // RL6 RL7 RL10

	// Counter and level: toggling on match gives equal halves of period+1 ticks
	always_comb begin
		tcnt_d  = tcnt_q;
		level_d = level_q;
		if (!buz_sel || start) begin
			tcnt_d  = 6'h00; // RL3
			level_d = 1'b0; // RL3
		end else if (tick) begin
			if (match) begin
				tcnt_d  = 6'h00; // RL4
				level_d = ~level_q; // RL2 RL4 RL6
			end else if (overflow) begin
				tcnt_d  = 6'h00; // RL5
			end else begin
				tcnt_d  = tcnt_q + 6'h01; // RL1
			end
		end
	end

	// Tone core registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= TONE_OFF;
			tcnt_q  <= 6'h00;
			level_q <= 1'b0;
		end else begin
			state_q <= buz_sel ? TONE_RUN : TONE_OFF; // RL8 RL9
			tcnt_q  <= tcnt_d;
			level_q <= level_d;
		end
	end

	// Pin drive: enable follows the buzzer function, level follows the core
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_q <= 1'b0;
			oe_q  <= 1'b0;
		end else begin
			out_q <= buz_sel & level_d; // RL2
			oe_q  <= buz_sel; // RL8 RL9
		end
	end

	// Pin level comes from outside the clock domain, two flops before use
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
		end else begin
			pin_meta_q <= buzzer_pin_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	// Protection bits carry no meaning here
	wire unused_prot = ^{awprot, arprot};

	assign awready        = awready_q;
	assign wready         = wready_q;
	assign bvalid         = bvalid_q;
	assign bresp          = bresp_q;
	assign arready        = arready_q;
	assign rvalid         = rvalid_q;
	assign rdata          = rdata_q;
	assign rresp          = rresp_q;
	assign buzzer_pin_out = out_q;
	assign buzzer_pin_oe  = oe_q;

endmodule : tone_square_wave_generator

`default_nettype wire

// ### dv/tone_monitor.sv
// Port checker of the tone generator, bound into its top module
`timescale 1ns/1ps
`default_nettype none
module tone_monitor #(
	parameter int DIV3 = 64
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [1:0]  bresp,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	input wire logic        buzzer_pin_out,
	input wire logic        buzzer_pin_oe
);
	// Longest half period: full 6-bit count at the slowest divider, plus start slack
	localparam int MAXH = 64 * DIV3 + 4;
	logic [13:0] run_q;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Cycles the driven pin has held its level
	always_ff @(posedge aclk) begin
		if (!aresetn || !buzzer_pin_oe || $changed(buzzer_pin_out)) run_q <= 14'h0;
		else run_q <= run_q + 14'h1;
	end

	a_enable_low: assert property ($rose(buzzer_pin_oe) |-> !buzzer_pin_out)
		else $error("pin not low at enable");
	a_idle_low: assert property (!buzzer_pin_oe |-> !buzzer_pin_out)
		else $error("tone level while not driving");
	a_toggle_hold: assert property (buzzer_pin_oe && $changed(buzzer_pin_out) |=>
		$stable(buzzer_pin_out) || !buzzer_pin_oe) else $error("half period too short");
	a_half_bound: assert property (run_q <= MAXH)
		else $error("half period too long");
	a_write_resp: assert property (awvalid && awready && wvalid && wready |=> bvalid)
		else $error("no write response");
	a_read_resp: assert property (arvalid && arready |=> rvalid)
		else $error("no read answer");
	a_bresp_stand: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_rdata_stand: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
endmodule : tone_monitor

bind tone_square_wave_generator tone_monitor #(.DIV3(DIV3)) i_tone_monitor (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
	.arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
	.rdata(rdata), .buzzer_pin_out(buzzer_pin_out), .buzzer_pin_oe(buzzer_pin_oe));
`default_nettype wire

// ### dv/tone_listener.sv
// Behavioural buzzer on the tone pin that measures half periods
`timescale 1ns/1ps
`default_nettype none
module tone_listener (
	input  wire logic        aclk,
	input  wire logic        drive,
	input  wire logic        level,
	output logic             pin,
	output logic [12:0]      half_len
);
	logic        alt_q = 1'b0;
	logic        last_q = 1'b0;
	logic [12:0] run_q = 13'h0;

	// Undriven pin floats: a changing level so a stale value is never trusted
	assign pin = drive ? level : alt_q;

	// Half period is the cycle count between two level changes while driven
	always @(posedge aclk) begin
		alt_q <= ~alt_q;
		last_q <= level;
		// Idle restarts at zero so the first half after enable is counted exactly
		if (!drive) run_q <= 13'h0;
		else if (level != last_q) run_q <= 13'h1;
		else run_q <= run_q + 13'h1;
		if (drive && level != last_q) half_len <= run_q;
	end
	initial half_len = 13'h0;
endmodule : tone_listener
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench of the tone generator
`timescale 1ns/1ps
`default_nettype none
`include "tone_defines.svh"
module tb_top;
	import tone_pkg::*;
	// Short dividers keep the run brief; code 11 stays at 64
	localparam int D0 = 2, D1 = 4, D2 = 8, D3 = 64;
	localparam logic [3:0] CT = `TONE_CTRL_OFFSET, PC = `TONE_PORTC_OFFSET;
	localparam logic [1:0] OK = `TONE_RESP_OKAY, SE = `TONE_RESP_SLVERR;
	typedef struct packed {logic [7:0] ctrl; logic [12:0] half;} row_t;
	row_t rows [4] = '{'{8'h00, 13'(D0)}, '{8'h43, 13'(D1 * 4)},
		'{8'h80, 13'(D2)}, '{8'hc1, 13'(D3 * 2)}};
	logic        aclk = 1'b0, aresetn = 1'b0, pin;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, p_out, p_oe;
	logic [12:0] half_len;
	int          bad_count = 0, n_checks = 0;

	always #20 aclk = ~aclk;

	tone_square_wave_generator #(.DIV0(D0), .DIV1(D1), .DIV2(D2), .DIV3(D3))
	i_tone_square_wave_generator (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.buzzer_pin_in(pin), .buzzer_pin_out(p_out), .buzzer_pin_oe(p_oe));
	tone_listener i_tone_listener (.aclk(aclk), .drive(p_oe), .level(p_out), .pin(pin),
		.half_len(half_len));

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	// Answer ready raised late so the slave must hold its response
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= s;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (n >= 2) bready <= 1'b1;
		end while (!(bvalid && bready) && n < 50);
		bready <= 1'b0;
		if (n >= 50) begin
			bad_count++;
			wrap_up();
		end
		chk(32'(bresp), 32'(er));
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
			if (n >= 2) rready <= 1'b1;
		end while (!(rvalid && rready) && n < 50);
		rready <= 1'b0;
		d = rdata;
		if (n >= 50) begin
			bad_count++;
			wrap_up();
		end
		chk(32'(rresp), 32'(er));
	endtask : rd

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		// Every prescaler code: start low, measure half period, stop
		foreach (rows[i]) begin
			wr(CT, rows[i].ctrl, 4'h1, OK);
			rd(CT, v, OK);
			chk(v, {24'h0, rows[i].ctrl});
			wr(PC, 8'h04, 4'h1, OK);
			@(negedge aclk);
			chk(32'(p_oe), 32'h1);
			chk(32'(p_out), 32'h0);
			repeat (int'(rows[i].half) * 4 + 8) @(posedge aclk);
			chk(32'(half_len), 32'(rows[i].half));
			wr(PC, 8'h00, 4'h1, OK);
			@(negedge aclk);
			chk(32'({p_oe, p_out}), 32'h0);
		end
		// Unmapped place, then an empty strobe that must not write
		wr(4'hc, 8'h12, 4'h1, SE);
		rd(4'hc, v, SE);
		chk(v, 32'h0);
		wr(CT, 8'h55, 4'h0, OK);
		rd(CT, v, OK);
		chk(v, 32'h0000_00c1);
		// Running flag, then a reset in mid-tone
		wr(PC, 8'h04, 4'h1, OK);
		rd(`TONE_STATUS_OFFSET, v, OK);
		chk(v & 32'h7, 32'h1);
		// After the first half the level and the synchronised pin both read high
		repeat (130) @(posedge aclk);
		rd(`TONE_STATUS_OFFSET, v, OK);
		chk(v & 32'h7, 32'h7);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk(32'(p_oe), 32'h0);
		rd(CT, v, OK);
		chk(v, 32'h0);
		rd(PC, v, OK);
		chk(v, 32'h0);
		// Period lowered below the count: 64 ticks to the wrap, then 6 to the match
		wr(CT, 8'h3f, 4'h1, OK);
		wr(PC, 8'h04, 4'h1, OK);
		repeat (40) @(posedge aclk);
		wr(CT, 8'h05, 4'h1, OK);
		repeat (100) @(posedge aclk);
		@(negedge aclk);
		chk(32'(half_len), 32'(D0 * (64 + 6)));
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
